// [src/isc_converter.v]
// Interlace scan converter: source multiplexer, line gate, divider and three line buffers.
//
// Functional notes
// - Every source register set captures RGB on the rising pixel clock edge.
// - Priority selection enables exactly one source onto the shared RGB bus.
// - Graphics register set has a clear that forces its contents to zero.
// - Composite blanking is registered before qualifying the write strobe.
// - Write strobe passes pixel clocks only while blanking is inactive.
// - Write strobe is further qualified by odd/even line: every other line.
// - Read strobes occur only during interlaced visible period.
// - Enabled read generator toggles each pixel clock, giving half-rate strobes.
// - Read strobes are suppressed while the buffer is empty.
// - Second toggle makes DAC clock at half rate, synchronised to read strobe.
// - Out-of-phase DAC clock holds an extra half period to realign.
// - Buffer is 512 deep, three 8-bit lanes, common strobes.
// - DAC gets halved clock, interlaced sync and interlaced blanking.
// - With adapter, image channels 1 and 2 pass through own buffers.
// - All three paths share one gate and one divider.
// - With adapter, channel 1 and 2 sync driver gets interlaced sync.
`include "isc_defs.vh"
`default_nettype none
module isc_converter (
  input wire clk_sys,
  input wire rst_n,
  input wire [`ISC_RGB_W-1:0] gfx_rgb,
  input wire [`ISC_RGB_W-1:0] img1_rgb,
  input wire [`ISC_RGB_W-1:0] img2_rgb,
  input wire [`ISC_RGB_W-1:0] dual_rgb,
  input wire [`ISC_SEL_W-1:0] source_select,
  input wire source_clear,
  input wire composite_blank_n,
  input wire odd_even_line,
  input wire interlaced_composite_blank_n,
  input wire interlaced_composite_sync_n,
  input wire adapter_present,
  input wire noninterlaced_sync_n,
  output reg [`ISC_RGB_W-1:0] dual_dac_rgb,
  output reg [`ISC_RGB_W-1:0] ch1_dac_rgb,
  output reg [`ISC_RGB_W-1:0] ch2_dac_rgb,
  output reg dac_clock,
  output reg dac_sync_n,
  output reg dac_blank_n,
  output reg ch12_sync_n,
  output reg write_strobe,
  output reg read_strobe
);

  ////////////////////////////////////////////////////////////////
  // Functions.

  // Three-stage pin synchroniser output is accepted when stages two and three agree.
  function filt;
    input s2;
    input s3;
    input prev;
    begin
      filt = (s2 == s3) ? s3 : prev;
    end
  endfunction

  // Packs red, green and blue into byte lanes.
  function [`ISC_RGB_W-1:0] pack_rgb;
    input [`ISC_RGB_W-1:0] v;
    begin
      pack_rgb = {v[`ISC_BLU_LSB +: `ISC_LANE_W], v[`ISC_GRN_LSB +: `ISC_LANE_W], v[`ISC_RED_LSB +: `ISC_LANE_W]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Source register sets and priority multiplexer.
  reg [`ISC_RGB_W-1:0] gfx_reg;
  reg [`ISC_RGB_W-1:0] img1_reg;
  reg [`ISC_RGB_W-1:0] img2_reg;
  reg [`ISC_RGB_W-1:0] dual_reg;
  reg [3:0] src_oe_reg;
  reg [`ISC_RGB_W-1:0] mux_rgb;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gfx_reg <= `ISC_RGB_RESET;
      img1_reg <= `ISC_RGB_RESET;
      img2_reg <= `ISC_RGB_RESET;
      dual_reg <= `ISC_RGB_RESET;
      src_oe_reg <= 4'h0;
    end
    else
    begin
      img1_reg <= img1_rgb;
      img2_reg <= img2_rgb;
      dual_reg <= dual_rgb;
      if (source_clear)
      begin
        gfx_reg <= `ISC_RGB_RESET;
      end
      else
      begin
        gfx_reg <= gfx_rgb;
      end
      case (source_select)
        `ISC_SEL_GFX: src_oe_reg <= 4'h1;
        `ISC_SEL_IMG1: src_oe_reg <= 4'h2;
        `ISC_SEL_IMG2: src_oe_reg <= 4'h4;
        default: src_oe_reg <= 4'h8;
      endcase
    end
  end

  // Only the enabled set reaches the shared bus.
  always @*
  begin
    mux_rgb = ({`ISC_RGB_W{src_oe_reg[0]}} & gfx_reg) | ({`ISC_RGB_W{src_oe_reg[1]}} & img1_reg)
      | ({`ISC_RGB_W{src_oe_reg[2]}} & img2_reg) | ({`ISC_RGB_W{src_oe_reg[3]}} & dual_reg);
  end

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers for the timing inputs.
  reg [2:0] blank_sync_reg;
  reg [2:0] oel_sync_reg;
  reg [2:0] iblank_sync_reg;
  reg [2:0] isync_sync_reg;
  reg [2:0] adapt_sync_reg;
  reg [2:0] nsync_sync_reg;
  reg blank_n_reg;
  reg oel_reg;
  reg iblank_n_reg;
  reg isync_n_reg;
  reg adapt_reg;
  reg nsync_n_reg;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blank_sync_reg <= 3'h0;
      oel_sync_reg <= 3'h0;
      iblank_sync_reg <= 3'h0;
      isync_sync_reg <= 3'h7;
      adapt_sync_reg <= 3'h0;
      nsync_sync_reg <= 3'h7;
      blank_n_reg <= 1'b0;
      oel_reg <= 1'b0;
      iblank_n_reg <= 1'b0;
      isync_n_reg <= 1'b1;
      adapt_reg <= 1'b0;
      nsync_n_reg <= 1'b1;
    end
    else
    begin
      blank_sync_reg <= {blank_sync_reg[1:0], composite_blank_n};
      oel_sync_reg <= {oel_sync_reg[1:0], odd_even_line};
      iblank_sync_reg <= {iblank_sync_reg[1:0], interlaced_composite_blank_n};
      isync_sync_reg <= {isync_sync_reg[1:0], interlaced_composite_sync_n};
      adapt_sync_reg <= {adapt_sync_reg[1:0], adapter_present};
      nsync_sync_reg <= {nsync_sync_reg[1:0], noninterlaced_sync_n};
      blank_n_reg <= filt(blank_sync_reg[1], blank_sync_reg[2], blank_n_reg);
      oel_reg <= filt(oel_sync_reg[1], oel_sync_reg[2], oel_reg);
      iblank_n_reg <= filt(iblank_sync_reg[1], iblank_sync_reg[2], iblank_n_reg);
      isync_n_reg <= filt(isync_sync_reg[1], isync_sync_reg[2], isync_n_reg);
      adapt_reg <= filt(adapt_sync_reg[1], adapt_sync_reg[2], adapt_reg);
      nsync_n_reg <= filt(nsync_sync_reg[1], nsync_sync_reg[2], nsync_n_reg);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shared alternate-line gate and divider.
  wire wr_next;
  wire rd_en;
  wire [2:0] fifo_empty;
  wire [2:0] fifo_in_ready;
  reg toggle_rd_reg;
  reg toggle_dac_reg;
  reg rd_pulse_reg;

  assign wr_next = blank_n_reg & oel_reg;
  assign rd_en = iblank_n_reg & ~(|fifo_empty);

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      toggle_rd_reg <= 1'b0;
      toggle_dac_reg <= 1'b0;
      rd_pulse_reg <= 1'b0;
    end
    else
    begin
      if (rd_en)
      begin
        toggle_rd_reg <= ~toggle_rd_reg;
      end
      else
      begin
        toggle_rd_reg <= 1'b0;
      end
      rd_pulse_reg <= rd_en & ~toggle_rd_reg;
      // The DAC clock follows the read toggle; a mismatch holds one cycle to realign.
      if (rd_en && toggle_dac_reg == toggle_rd_reg)
      begin
        toggle_dac_reg <= ~toggle_dac_reg;
      end
      else if (!rd_en)
      begin
        toggle_dac_reg <= toggle_dac_reg ^ 1'b1;
      end
      else
      begin
        toggle_dac_reg <= toggle_dac_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Three interlace line buffers on common strobes.
  wire [`ISC_RGB_W-1:0] buf_out [0:2];
  wire [`ISC_RGB_W-1:0] buf_in [0:2];
  wire [3*`ISC_RGB_W-1:0] skid_in;
  wire [3*`ISC_RGB_W-1:0] skid_out;
  wire skid_valid;
  wire wr_go;

  assign buf_in[0] = pack_rgb(mux_rgb);
  assign buf_in[1] = pack_rgb(img1_reg);
  assign buf_in[2] = pack_rgb(img2_reg);
  assign skid_in = {buf_in[2], buf_in[1], buf_in[0]};
  // The skid stage always drains, so it adds one cycle of latency and no storage.
  assign wr_go = skid_valid & (&fifo_in_ready);

  // Four-word stage in the write path; words that meet full line buffers are dropped.
  isc_fifo #(
    .WIDTH(3*`ISC_RGB_W),
    .DEPTH(`ISC_SKID_DEPTH),
    .AW(`ISC_SKID_AW)
  ) u_skid (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_data(skid_in),
    .in_valid(wr_next),
    .in_ready(),
    .out_data(skid_out),
    .out_valid(skid_valid),
    .out_ready(1'b1),
    .empty(),
    .full()
  );

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_line
      isc_fifo #(
        .WIDTH(`ISC_RGB_W),
        .DEPTH(`ISC_LINE_DEPTH),
        .AW(`ISC_LINE_AW)
      ) u_line (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_data(skid_out[gi*`ISC_RGB_W +: `ISC_RGB_W]),
        .in_valid(wr_go),
        .in_ready(fifo_in_ready[gi]),
        .out_data(buf_out[gi]),
        .out_valid(),
        .out_ready(rd_pulse_reg),
        .empty(fifo_empty[gi]),
        .full()
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // DAC and sync driver outputs.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dual_dac_rgb <= `ISC_RGB_RESET;
      ch1_dac_rgb <= `ISC_RGB_RESET;
      ch2_dac_rgb <= `ISC_RGB_RESET;
      dac_clock <= 1'b0;
      dac_sync_n <= 1'b1;
      dac_blank_n <= 1'b0;
      ch12_sync_n <= 1'b1;
      write_strobe <= 1'b0;
      read_strobe <= 1'b0;
    end
    else
    begin
      if (rd_pulse_reg)
      begin
        dual_dac_rgb <= buf_out[0];
        ch1_dac_rgb <= adapt_reg ? buf_out[1] : img1_reg;
        ch2_dac_rgb <= adapt_reg ? buf_out[2] : img2_reg;
      end
      dac_clock <= toggle_dac_reg;
      dac_sync_n <= isync_n_reg;
      dac_blank_n <= iblank_n_reg;
      ch12_sync_n <= adapt_reg ? isync_n_reg : nsync_n_reg;
      write_strobe <= wr_go;
      read_strobe <= rd_pulse_reg;
    end
  end
endmodule // isc_converter
`default_nettype wire

// [src/isc_defs.vh]
// Constants shared by the interlace scan converter design files.
`ifndef ISC_DEFS_VH
`define ISC_DEFS_VH
`define ISC_LANE_W 8
`define ISC_RGB_W 24
`define ISC_RED_LSB 0
`define ISC_GRN_LSB 8
`define ISC_BLU_LSB 16
`define ISC_LINE_DEPTH 512
`define ISC_LINE_AW 9
`define ISC_SKID_DEPTH 4
`define ISC_SKID_AW 2
`define ISC_RGB_RESET 24'h000000
`define ISC_SEL_W 2
`define ISC_SEL_GFX 2'h0
`define ISC_SEL_IMG1 2'h1
`define ISC_SEL_IMG2 2'h2
`define ISC_SEL_DUAL 2'h3
`endif

// [src/isc_fifo.v]
// Parameterised synchronous FIFO with valid and ready on both sides.
`default_nettype none
module isc_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 512,
  parameter AW = 9
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire empty,
  output wire full
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire do_wr;
  wire do_rd;

  assign full = (count_reg == DEPTH[AW:0]);
  assign empty = (count_reg == {(AW+1){1'b0}});
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem_reg[rd_ptr_reg];
  assign do_wr = in_valid & ~full;
  assign do_rd = out_ready & ~empty;

  ////////////////////////////////////////////////////////////////
  // Storage is written without reset.
  always @(posedge clk_sys)
  begin
    if (do_wr)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pointers and fill count.
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // isc_fifo
`default_nettype wire

// [verification/isc_converter_properties.sv]
// Concurrent checks on the interlace scan converter ports.
`default_nettype none
module isc_converter_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic composite_blank_n,
  input wire logic odd_even_line,
  input wire logic interlaced_composite_blank_n,
  input wire logic interlaced_composite_sync_n,
  input wire logic adapter_present,
  input wire logic [23:0] dual_dac_rgb,
  input wire logic [23:0] ch1_dac_rgb,
  input wire logic [23:0] ch2_dac_rgb,
  input wire logic dac_clock,
  input wire logic dac_sync_n,
  input wire logic ch12_sync_n,
  input wire logic write_strobe,
  input wire logic read_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] fill_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  // Words held in the buffers, counted from the strobe copies.
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      fill_reg <= 10'h000;
    else
      fill_reg <= fill_reg + {9'h000, write_strobe} - {9'h000, read_strobe};
  ////////////////////////////////////////////////////////////////
  a_read_spacing: assert property (read_strobe |=> !read_strobe)
    else $error("read strobes back to back");
  a_read_nonempty: assert property (read_strobe |-> fill_reg != 10'h000)
    else $error("read from empty buffer");
  a_read_blanked: assert property (!interlaced_composite_blank_n [*7] |-> !read_strobe)
    else $error("read during interlaced blanking");
  a_write_blanked: assert property (!composite_blank_n [*7] |-> !write_strobe)
    else $error("write during blanking");
  a_write_oddline: assert property (!odd_even_line [*7] |-> !write_strobe)
    else $error("write on skipped line");
  a_dac_hold: assert property (!read_strobe |-> $stable(dual_dac_rgb))
    else $error("dac data moved without read");
  a_paths_shared: assert property (!read_strobe |-> $stable(ch1_dac_rgb) && $stable(ch2_dac_rgb))
    else $error("channel data moved without shared read");
  a_sync_follow: assert property (interlaced_composite_sync_n [*6] |-> dac_sync_n)
    else $error("dac sync not following interlaced sync");
  a_ch12_sync: assert property ((adapter_present && !interlaced_composite_sync_n) [*6] |-> !ch12_sync_n)
    else $error("channel sync not interlaced");
  a_dac_half_rate: assert property (read_strobe ##2 read_strobe ##2 read_strobe |-> dac_clock != $past(dac_clock))
    else $error("dac clock not at half rate");
  c_write: cover property (write_strobe);
  c_reads: cover property (read_strobe ##2 read_strobe);
  c_ch12: cover property (!ch12_sync_n);
endmodule // isc_converter_properties
`default_nettype wire

// [verification/isc_dac_model.sv]
// Behavioural model of the video DAC fed by the converter.
`default_nettype none
module isc_dac_model (
  input wire logic clk_sys,
  input wire logic dac_clock,
  input wire logic [23:0] rgb,
  input wire logic sync_n,
  input wire logic blank_n,
  output logic [23:0] shown_rgb,
  output logic shown_sync_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_prev = 1'b0;
  initial shown_rgb = 24'h000000;
  initial shown_sync_n = 1'b1;
  // Capture on each rising DAC clock; blanked pixels show zero.
  always @(posedge clk_sys)
  begin
    clk_prev <= dac_clock;
    if (dac_clock && !clk_prev)
    begin
      shown_rgb <= blank_n ? rgb : 24'h000000;
      shown_sync_n <= sync_n;
    end
  end
endmodule // isc_dac_model
`default_nettype wire

// [verification/tb_isc_converter.sv]
// Self-checking bench for the interlace scan converter.
`default_nettype none
module tb_isc_converter;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst_n = 1'b0, source_clear = 1'b0, composite_blank_n = 1'b0;
  logic [23:0] gfx_rgb = 24'h000000, img1_rgb = 24'h000000, img2_rgb = 24'h000000, dual_rgb = 24'h000000;
  logic [1:0] source_select = 2'h0;
  logic odd_even_line = 1'b0, interlaced_composite_blank_n = 1'b0, interlaced_composite_sync_n = 1'b1;
  logic adapter_present = 1'b1, noninterlaced_sync_n = 1'b1;
  wire [23:0] dual_dac_rgb, ch1_dac_rgb, ch2_dac_rgb, shown_rgb;
  wire dac_clock, dac_sync_n, dac_blank_n, ch12_sync_n, write_strobe, read_strobe, shown_sync_n;
  logic [23:0] q_dual[$], q_c1[$], q_c2[$], last_dual;
  int err_total = 0, cmp_count = 0, wr_seen = 0, wr_exp = 0;
  always #4 clk_sys = ~clk_sys;
  isc_converter i_dut (.clk_sys, .rst_n, .gfx_rgb, .img1_rgb, .img2_rgb, .dual_rgb, .source_select,
    .source_clear, .composite_blank_n, .odd_even_line, .interlaced_composite_blank_n,
    .interlaced_composite_sync_n, .adapter_present, .noninterlaced_sync_n, .dual_dac_rgb, .ch1_dac_rgb,
    .ch2_dac_rgb, .dac_clock, .dac_sync_n, .dac_blank_n, .ch12_sync_n, .write_strobe, .read_strobe);
  isc_dac_model i_dac (.clk_sys, .dac_clock, .rgb(dual_dac_rgb), .sync_n(dac_sync_n),
    .blank_n(dac_blank_n), .shown_rgb, .shown_sync_n);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Each read must deliver the next stored word on all three paths.
  always @(posedge clk_sys)
  begin
    if (write_strobe === 1'b1)
      wr_seen <= wr_seen + 1;
    if (read_strobe === 1'b1)
    begin
      chk("dac_clock", 24'h000001, {23'h000000, dac_clock});
      if (q_dual.size() == 0)
        chk("read count", 24'h000000, 24'h000001);
      else
      begin
        last_dual = q_dual.pop_front();
        chk("dual_dac_rgb", last_dual, dual_dac_rgb);
        chk("ch1_dac_rgb", q_c1.pop_front(), ch1_dac_rgb);
        chk("ch2_dac_rgb", q_c2.pop_front(), ch2_dac_rgb);
      end
    end
  end
  // One scan line: sources settle in blanking, then len visible pixels.
  task automatic line(input int len, input logic store, input logic [1:0] sel, input logic clr);
    logic [23:0] v;
    gfx_rgb <= $urandom;
    img1_rgb <= $urandom;
    img2_rgb <= $urandom;
    dual_rgb <= $urandom;
    source_select <= sel;
    source_clear <= clr;
    odd_even_line <= store;
    adapter_present <= !clr;
    noninterlaced_sync_n <= clr;
    interlaced_composite_sync_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("dac_sync_n", 24'h000000, {23'h000000, dac_sync_n});
    chk("dac_blank_n", 24'h000000, {23'h000000, dac_blank_n});
    chk("ch12_sync_n", {23'h000000, clr}, {23'h000000, ch12_sync_n});
    chk("dac model sync", 24'h000000, {23'h000000, shown_sync_n});
    interlaced_composite_sync_n <= 1'b1;
    composite_blank_n <= 1'b1;
    repeat (len) @(posedge clk_sys);
    composite_blank_n <= 1'b0;
    case (sel)
      2'h0: v = clr ? 24'h000000 : gfx_rgb;
      2'h1: v = img1_rgb;
      2'h2: v = img2_rgb;
      default: v = dual_rgb;
    endcase
    for (int k = 0; store && k < len && q_dual.size() < 512; k++)
    begin
      q_dual.push_back(v);
      q_c1.push_back(img1_rgb);
      q_c2.push_back(img2_rgb);
      wr_exp++;
    end
    repeat (8) @(posedge clk_sys);
  endtask
  // Empty the buffers with a blanking stall part way through.
  task automatic drain(input int stall);
    int n = 0;
    chk("write count", wr_exp[23:0], wr_seen[23:0]);
    interlaced_composite_blank_n <= 1'b1;
    while (q_dual.size() > 0 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
      if (n == stall)
        interlaced_composite_blank_n <= 1'b0;
      if (n == stall + 12)
        interlaced_composite_blank_n <= 1'b1;
    end
    repeat (20) @(posedge clk_sys);
    chk("words left", 24'h000000, q_dual.size());
    chk("dac model rgb", last_dual, shown_rgb);
    interlaced_composite_blank_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  initial
  begin
    void'($urandom(32'h8cfd28a5));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 10; i++)
      line(3 + $urandom % 30, i != 4 && i != 7, i[1:0], i == 8);
    drain(9);
    $display("test lines done");
    line(600, 1'b1, 2'h3, 1'b0);
    drain(40);
    $display("test fill done");
    test_done;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    test_done;
  end
endmodule // tb_isc_converter
bind isc_converter isc_converter_properties i_props (.clk_sys, .rst_n, .composite_blank_n, .odd_even_line,
  .interlaced_composite_blank_n, .interlaced_composite_sync_n, .adapter_present, .dual_dac_rgb,
  .ch1_dac_rgb, .ch2_dac_rgb, .dac_clock, .dac_sync_n, .ch12_sync_n, .write_strobe, .read_strobe);
`default_nettype wire
